// ---- hdl/msc_in_filter.sv ----
module msc_in_filter #(
    parameter int N = 6
) (
    input wire logic ref_clk,
    input wire logic reset,
    msc_in_if.filter pins
);

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_bit
            logic sync1_q;
            logic sync2_q;
            logic sync3_q;
            logic level_q;
            logic rise_q;
            logic [msc_pkg::DEBOUNCE_W-1:0] count_q;

            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    sync1_q <= 1'b0;
                    sync2_q <= 1'b0;
                    sync3_q <= 1'b0;
                end else begin
                    sync1_q <= pins.raw[i];
                    sync2_q <= sync1_q;
                    sync3_q <= sync2_q;
                end
            end

            // a change counts only while stages two and three agree for the full time
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    count_q <= '0;
                    level_q <= 1'b0;
                    rise_q <= 1'b0;
                end else begin
                    rise_q <= 1'b0;
                    if (sync2_q != sync3_q || sync3_q == level_q) begin
                        count_q <= '0;
                    end else if (count_q == msc_pkg::DEBOUNCE_LAST) begin
                        count_q <= '0;
                        level_q <= sync3_q;
                        rise_q <= sync3_q;
                    end else begin
                        count_q <= count_q + 1'b1;
                    end
                end
            end

            assign pins.level[i] = level_q;
            assign pins.rise[i] = rise_q;
        end
    endgenerate

endmodule

// ---- hdl/msc_io_logic.sv ----
module msc_io_logic #(
    parameter int EDGES_PER_REV = 24
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [msc_pkg::NUM_INPUTS-1:0] generalInput,
    input wire logic inputMapOverride,
    input wire logic [msc_pkg::NUM_INPUTS*msc_pkg::IN_FN_W-1:0] inputMap,
    input wire logic outputMapOverride,
    input wire logic [msc_pkg::NUM_OUTPUTS*msc_pkg::OUT_FN_W-1:0] outputMap,
    input wire logic directionInvert,
    input wire logic motorStopped,
    input wire logic faultDetect,
    input wire logic rotorEdge,
    output logic [msc_pkg::NUM_OUTPUTS-1:0] generalOutput,
    output logic driveEnable,
    output logic driveReverse,
    output logic rampStop,
    output logic instantStop,
    output logic coastStop,
    output logic [1:0] dataIndex,
    output logic alarmActive,
    output logic [1:0] alarmCode,
    output logic [1:0] motorState
);

    localparam int NI = msc_pkg::NUM_INPUTS;
    localparam int NO = msc_pkg::NUM_OUTPUTS;
    localparam int FW = msc_pkg::IN_FN_W;
    localparam int OW = msc_pkg::OUT_FN_W;
    localparam logic [msc_pkg::ACC_W-1:0] ACC_STEP = msc_pkg::ACC_W'(2 * msc_pkg::PULSES_PER_REV);
    localparam logic [msc_pkg::ACC_W-1:0] ACC_WRAP = msc_pkg::ACC_W'(EDGES_PER_REV);

    msc_in_if #(.N(NI)) inBus ();

    logic [NI*FW-1:0] inMap;
    logic [NO*OW-1:0] outMap;
    logic forwardRun;
    logic reverseRun;
    logic selLow;
    logic selHigh;
    logic clearRise;
    logic coastOn;
    logic blocked;
    logic eitherRun;
    logic bothRun;
    logic reverseWanted;

    msc_pkg::msc_state_e state_q;
    msc_pkg::msc_state_e state_d;
    msc_pkg::msc_alarm_e alarm_q;
    logic [msc_pkg::POWERON_W-1:0] poweronCnt_q;
    logic poweronDone_q;
    logic [msc_pkg::ACC_W-1:0] acc_q;
    logic speedLevel_q;

    // any input carrying the wanted function asserts it; duplicates OR together
    function automatic logic fnActive(
        input logic [NI*FW-1:0] map,
        input logic [NI-1:0] bits,
        input msc_pkg::msc_in_fn_e fn
    );
        logic hit;
        hit = 1'b0;
        for (int k = 0; k < NI; k++) begin
            if (map[k*FW +: FW] == fn && bits[k]) begin
                hit = 1'b1;
            end
        end
        return hit;
    endfunction

    assign inBus.raw = generalInput;

    msc_in_filter #(.N(NI)) u_filter (
        .ref_clk(ref_clk),
        .reset(reset),
        .pins(inBus.filter)
    );

    assign inMap = inputMapOverride ? inputMap : msc_pkg::DEFAULT_IN_MAP;
    assign outMap = outputMapOverride ? outputMap : msc_pkg::DEFAULT_OUT_MAP;

    assign forwardRun = fnActive(inMap, inBus.level, msc_pkg::FN_FORWARD);
    assign reverseRun = fnActive(inMap, inBus.level, msc_pkg::FN_REVERSE);
    assign selLow = fnActive(inMap, inBus.level, msc_pkg::FN_SEL_LOW);
    assign selHigh = fnActive(inMap, inBus.level, msc_pkg::FN_SEL_HIGH);
    assign clearRise = fnActive(inMap, inBus.rise, msc_pkg::FN_ALARM_CLEAR);
    assign coastOn = fnActive(inMap, inBus.level, msc_pkg::FN_COAST);

    assign eitherRun = forwardRun ^ reverseRun;
    assign bothRun = forwardRun & reverseRun;
    // an alarm holds the motor off just as coast does
    assign blocked = coastOn | (alarm_q != msc_pkg::ALM_NONE);

    assign reverseWanted = reverseRun ^ directionInvert;

    // run check waits for filters to settle so a held input is really seen
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            poweronCnt_q <= '0;
            poweronDone_q <= 1'b0;
        end else if (!poweronDone_q) begin
            if (poweronCnt_q == msc_pkg::POWERON_CHECK_CYC) begin
                poweronDone_q <= 1'b1;
            end else begin
                poweronCnt_q <= poweronCnt_q + 1'b1;
            end
        end
    end

    // a new alarm in the clear cycle wins over the clear
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarm_q <= msc_pkg::ALM_NONE;
        end else if (!poweronDone_q && poweronCnt_q == msc_pkg::POWERON_CHECK_CYC
                && (forwardRun || reverseRun)) begin
            alarm_q <= msc_pkg::ALM_POWERON;
        end else if (faultDetect) begin
            alarm_q <= msc_pkg::ALM_FAULT;
        end else if (clearRise) begin
            alarm_q <= msc_pkg::ALM_NONE;
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            msc_pkg::ST_IDLE: begin
                if (!blocked && poweronDone_q && eitherRun) begin
                    state_d = msc_pkg::ST_RUN;
                end
            end
            msc_pkg::ST_RUN: begin
                if (blocked) begin
                    state_d = msc_pkg::ST_COAST;
                end else if (bothRun) begin
                    state_d = msc_pkg::ST_IDLE;
                end else if (!eitherRun) begin
                    state_d = msc_pkg::ST_DECEL;
                end
            end
            msc_pkg::ST_DECEL: begin
                if (blocked) begin
                    state_d = msc_pkg::ST_COAST;
                end else if (bothRun || motorStopped) begin
                    state_d = msc_pkg::ST_IDLE;
                end else if (eitherRun) begin
                    state_d = msc_pkg::ST_RUN;
                end
            end
            msc_pkg::ST_COAST: begin
                // both runs end a coast at once
                if (!blocked && (motorStopped || bothRun)) begin
                    state_d = msc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = msc_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_q <= msc_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // drive outputs follow the next state so they change with the state itself
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            driveEnable <= 1'b0;
            motorState <= msc_pkg::ST_IDLE;
        end else begin
            driveEnable <= (state_d == msc_pkg::ST_RUN);
            motorState <= state_d;
        end
    end

    // direction held from the last running cycle so a ramp keeps its sense
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            driveReverse <= 1'b0;
        end else if (state_d == msc_pkg::ST_RUN) begin
            driveReverse <= reverseWanted;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rampStop <= 1'b0;
            coastStop <= 1'b0;
        end else begin
            rampStop <= (state_d == msc_pkg::ST_DECEL);
            coastStop <= (state_d == msc_pkg::ST_COAST);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            instantStop <= 1'b0;
        end else begin
            instantStop <= bothRun && !blocked && poweronDone_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            dataIndex <= 2'h0;
        end else begin
            dataIndex <= {selHigh, selLow};
        end
    end

    // each rotor edge adds twice the pulse rate; every wrap toggles the level
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            acc_q <= '0;
            speedLevel_q <= 1'b0;
        end else if (rotorEdge) begin
            if (acc_q + ACC_STEP >= ACC_WRAP) begin
                acc_q <= acc_q + ACC_STEP - ACC_WRAP;
                speedLevel_q <= ~speedLevel_q;
            end else begin
                acc_q <= acc_q + ACC_STEP;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarmActive <= 1'b0;
        end else begin
            alarmActive <= (alarm_q != msc_pkg::ALM_NONE);
        end
    end

    // code moves on the same edge as the flag so a reader never sees a mixed pair
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            alarmCode <= msc_pkg::ALM_NONE;
        end else begin
            alarmCode <= alarm_q;
        end
    end

    genvar j;
    generate
        for (j = 0; j < NO; j++) begin : g_out
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    generalOutput[j] <= 1'b0;
                end else begin
                    case (outMap[j*OW +: OW])
                        msc_pkg::OFN_SPEED_PULSE: begin
                            generalOutput[j] <= speedLevel_q;
                        end
                        msc_pkg::OFN_ALARM_NC: begin
                            generalOutput[j] <= (alarm_q == msc_pkg::ALM_NONE);
                        end
                        msc_pkg::OFN_RUNNING: begin
                            generalOutput[j] <= (state_q == msc_pkg::ST_RUN);
                        end
                        default: begin
                            generalOutput[j] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

endmodule

// ---- inc/msc_in_if.sv ----
interface msc_in_if #(
    parameter int N = 6
);
    logic [N-1:0] raw;
    logic [N-1:0] level;
    logic [N-1:0] rise;

    modport filter (
        input raw,
        output level,
        output rise
    );

    modport user (
        output raw,
        input level,
        input rise
    );
endinterface

// ---- inc/msc_pkg.sv ----
package msc_pkg;

    localparam int CLK_PERIOD_NS = 5;
    // least settling time of an isolated input before a change is believed
    localparam int DEBOUNCE_NS = 2000;
    localparam int DEBOUNCE_CYC = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DEBOUNCE_W = 9;
    localparam logic [DEBOUNCE_W-1:0] DEBOUNCE_LAST = DEBOUNCE_W'(DEBOUNCE_CYC - 1);

    // power-on run check waits for the filters to settle first
    localparam int POWERON_W = 10;
    localparam logic [POWERON_W-1:0] POWERON_CHECK_CYC = POWERON_W'(DEBOUNCE_CYC + 8);

    localparam int PULSES_PER_REV = 12;
    localparam int NUM_INPUTS = 6;
    localparam int NUM_OUTPUTS = 2;
    localparam int IN_FN_W = 3;
    localparam int OUT_FN_W = 2;

    typedef enum logic [2:0] {
        FN_NONE = 3'h0,
        FN_FORWARD = 3'h1,
        FN_REVERSE = 3'h2,
        FN_SEL_LOW = 3'h3,
        FN_SEL_HIGH = 3'h4,
        FN_ALARM_CLEAR = 3'h5,
        FN_COAST = 3'h6
    } msc_in_fn_e;

    typedef enum logic [1:0] {
        OFN_NONE = 2'h0,
        OFN_SPEED_PULSE = 2'h1,
        OFN_ALARM_NC = 2'h2,
        OFN_RUNNING = 2'h3
    } msc_out_fn_e;

    // inputs a..f: forward, reverse, select low, select high, alarm clear, coast
    localparam logic [NUM_INPUTS*IN_FN_W-1:0] DEFAULT_IN_MAP = 18'h358d1;
    // output a: speed pulse, output b: alarm (normally closed)
    localparam logic [NUM_OUTPUTS*OUT_FN_W-1:0] DEFAULT_OUT_MAP = 4'h9;

    // gray order along idle -> run -> decel -> coast -> idle
    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN = 2'h1,
        ST_DECEL = 2'h3,
        ST_COAST = 2'h2
    } msc_state_e;

    typedef enum logic [1:0] {
        ALM_NONE = 2'h0,
        ALM_POWERON = 2'h1,
        ALM_FAULT = 2'h2
    } msc_alarm_e;

    localparam int ACC_W = 16;

endpackage

// ---- verification/motor_speed_ctrl_io_logic_tb.sv ----
module motor_speed_ctrl_io_logic_tb;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SETTLE = msc_pkg::DEBOUNCE_CYC + 20;
    localparam logic [13:0] NC = 14'h0002, DE = 14'h0004, DR = 14'h0008, RS = 14'h0010;
    localparam logic [13:0] IS = 14'h0020, CS = 14'h0040, DI = 14'h0180, AA = 14'h0200;
    localparam logic [13:0] AC = 14'h0c00, ST = 14'h3000;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic inMapOn = 1'b0;
    logic [17:0] inMap = msc_pkg::DEFAULT_IN_MAP;
    logic dirInv = 1'b0;
    logic fault = 1'b0;
    logic [5:0] pins;
    logic stopped, edgeP, dEn, dRev, rStop, iStop, cStop, aAct;
    logic [1:0] gOut, dIdx, aCode, mState, v;
    logic [13:0] obs, m, x, qe[$], qm[$];
    logic outMapOn = 1'b0;
    int error_cnt = 0;
    int num_checks = 0;
    int pulses = 0;
    int r;
    event take;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
    assign obs = {mState, aCode, aAct, dIdx, cStop, iStop, rStop, dRev, dEn, gOut};
    initial forever #2.5 ref_clk = ~ref_clk;
    msc_ctrl_model model (.ref_clk(ref_clk), .driveEnable(dEn), .pins(pins),
        .motorStopped(stopped), .rotorEdge(edgeP));
    msc_io_logic dut (.ref_clk(ref_clk), .reset(reset), .generalInput(pins),
        .inputMapOverride(inMapOn), .inputMap(inMap), .outputMapOverride(outMapOn),
        .outputMap({msc_pkg::OFN_RUNNING, msc_pkg::OFN_SPEED_PULSE}), .directionInvert(dirInv),
        .motorStopped(stopped), .faultDetect(fault), .rotorEdge(edgeP),
        .generalOutput(gOut), .driveEnable(dEn), .driveReverse(dRev), .rampStop(rStop),
        .instantStop(iStop), .coastStop(cStop), .dataIndex(dIdx), .alarmActive(aAct),
        .alarmCode(aCode), .motorState(mState));
    always @(posedge gOut[0]) pulses++;
    always @(take) begin
        while (qe.size() > 0) begin
            m = qm.pop_front();
            x = qe.pop_front();
            `CHK(obs & m, x)
        end
    end
    task automatic note(input logic [13:0] mk, input logic [13:0] e);
        qm.push_back(mk);
        qe.push_back(e);
        -> take;
    endtask
    task automatic pin(input int k, input logic b);
        model.setPin(k, b);
        repeat (SETTLE) @(posedge ref_clk);
        #1;
    endtask
    task automatic stop_test();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32));
        // forward held across power-up
        model.setPin(0, 1'b1);
        repeat (15) @(posedge ref_clk);
        #1 reset = 1'b0;
        pin(4, 1'b0);
        note(DE | AA | AC | NC, AA | 14'h0400);
        pin(4, 1'b1);
        note(DE | DR | AA | NC, DE | NC);
        pin(4, 1'b0);
        pulses = 0;
        model.spin(24);
        repeat (4) @(posedge ref_clk);
        `CHK(pulses, 12)
        r = $urandom;
        for (int i = 0; i < 4; i++) begin
            v = 2'((r + i) % 4);
            // both selects move together so the index never shows a mixed pair
            model.setSel(v);
            repeat (SETTLE) @(posedge ref_clk);
            #1;
            note(DI, {5'h00, v, 7'h00});
        end
        // a short contact bounce must not move the index
        model.setPin(2, ~v[0]);
        repeat (100) @(posedge ref_clk);
        pin(2, v[0]);
        note(DI, {5'h00, v, 7'h00});
        pin(5, 1'b1);
        note(DE | CS, CS);
        pin(0, 1'b0);
        pin(0, 1'b1);
        note(DE, 14'h0000);
        pin(5, 1'b0);
        note(DE | CS | DR, DE);
        pin(1, 1'b1);
        note(DE | IS, IS);
        pin(0, 1'b0);
        note(DE | DR | IS, DE | DR);
        @(posedge ref_clk);
        #1 dirInv = 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 note(DE | DR, DE);
        dirInv = 1'b0;
        model.setPin(1, 1'b0);
        for (int i = 0; i <= SETTLE && rStop !== 1'b1; i++) @(posedge ref_clk);
        if (rStop !== 1'b1) error_cnt++;
        #1 note(DE | RS | ST, RS | ST);
        repeat (SETTLE) @(posedge ref_clk);
        #1 note(ST | DE, 14'h0000);
        inMap = {msc_pkg::DEFAULT_IN_MAP[17:3], 3'h2};
        inMapOn = 1'b1;
        outMapOn = 1'b1;
        pin(0, 1'b1);
        note(DE | DR | NC, DE | DR | NC);
        pin(0, 1'b0);
        note(RS | NC, RS);
        inMapOn = 1'b0;
        outMapOn = 1'b0;
        #1 fault = 1'b1;
        @(posedge ref_clk);
        #1 fault = 1'b0;
        repeat (4) @(posedge ref_clk);
        note(AA | AC | NC, AA | 14'h0800);
        pin(4, 1'b1);
        note(AA | NC, NC);
        repeat (8) @(posedge ref_clk);
        stop_test();
    end
endmodule

// ---- verification/msc_ctrl_model.sv ----
module msc_ctrl_model (
    input wire logic ref_clk,
    input wire logic driveEnable,
    output logic [5:0] pins,
    output logic motorStopped,
    output logic rotorEdge
);
    timeunit 1ns;
    timeprecision 100ps;
    int idleCnt = 0;
    initial pins = 6'h00;
    initial rotorEdge = 1'b0;
    // shaft coasts a while before it reads as stopped
    always @(posedge ref_clk) begin
        idleCnt <= driveEnable ? 0 : idleCnt + 1;
    end
    assign motorStopped = idleCnt > 30;
    task automatic setPin(input int k, input logic v);
        @(posedge ref_clk);
        #1 pins[k] = v;
    endtask
    task automatic setSel(input logic [1:0] v);
        @(posedge ref_clk);
        #1 pins[3:2] = v;
    endtask
    task automatic spin(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1 rotorEdge = 1'b1;
            @(posedge ref_clk);
            #1 rotorEdge = 1'b0;
            repeat (3) @(posedge ref_clk);
        end
    endtask
endmodule

// ---- verification/msc_io_assertions.sv ----
module msc_io_assertions (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [5:0] generalInput,
    input wire logic inputMapOverride,
    input wire logic faultDetect,
    input wire logic rotorEdge,
    input wire logic [1:0] generalOutput,
    input wire logic driveEnable,
    input wire logic instantStop,
    input wire logic rampStop,
    input wire logic coastStop,
    input wire logic [1:0] dataIndex,
    input wire logic alarmActive,
    input wire logic [1:0] alarmCode,
    input wire logic [1:0] motorState
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [9:0] upCnt_q;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            upCnt_q <= 10'h000;
        end else if (upCnt_q != 10'h3ff) begin
            upCnt_q <= upCnt_q + 10'h001;
        end
    end
    a_coast_undriven: assert property (coastStop |-> !driveEnable)
        else $error("drive on during coast");
    a_no_early_run: assert property (upCnt_q < 10'h190 |-> !driveEnable)
        else $error("drive before power-on check");
    a_run_state: assert property ($rose(driveEnable) |-> motorState == msc_pkg::ST_RUN)
        else $error("drive without run state");
    a_instant_idle: assert property (instantStop |-> !driveEnable && motorState == msc_pkg::ST_IDLE)
        else $error("instant stop while driven");
    a_ramp_decel: assert property (rampStop |-> !driveEnable && motorState == msc_pkg::ST_DECEL)
        else $error("ramp stop outside decel");
    a_fault_latch: assert property (faultDetect |-> ##[1:2] alarmActive && alarmCode == msc_pkg::ALM_FAULT)
        else $error("fault not latched");
    a_alarm_opens: assert property ($rose(alarmActive) |-> ##[0:1] !generalOutput[1])
        else $error("alarm output still closed");
    a_pulse_cause: assert property ($changed(generalOutput[0]) |-> $past(rotorEdge) || $past(rotorEdge, 2))
        else $error("speed pulse without rotor edge");
    a_index_pins: assert property ($changed(dataIndex) && !inputMapOverride |-> dataIndex == generalInput[3:2])
        else $error("index differs from select pins");
endmodule

bind msc_io_logic msc_io_assertions chk (.*);
